// ---- rtl/hword_load_consts.vh ----
// constants for the signed halfword load unit
`ifndef HWORD_LOAD_CONSTS_VH
`define HWORD_LOAD_CONSTS_VH
`define OPC_HWORD_DISP 8'h06
`define OPC_HWORD_INDEXED 8'hc3
`define OPC_WIDTH 8
`define DISP_WIDTH 7
`define DISP_SIGN_BIT 6
`define HWORD_SIGN_BIT 15
`define BYTE_LO_MSB 7
`define BYTE_HI_MSB 15
`define BYTE_HI_LSB 8
`define ADDR_ALIGN_BIT 0
`define ORDER_LITTLE 1'b1
`define LOAD_LATENCY 3
`define ZERO_WORD 32'h00000000
`define ZERO_HALF 16'h0000
`define ZERO_ADDR 32'h00000000
`define ZERO_REGIDX 7'h00
`endif

// ---- rtl/hword_assemble.v ----
// byte ordering and sign extension of a fetched halfword
`timescale 1ns/1ps
`include "hword_load_consts.vh"
module hword_assemble (
  input wire [7:0] byteAtBase,
  input wire [7:0] byteAtNext,
  input wire littleEndian,
  output wire [31:0] extended
);
  wire [15:0] half;
  assign half = littleEndian ? {byteAtNext, byteAtBase} :
                               {byteAtBase, byteAtNext};
  assign extended = {{16{half[`HWORD_SIGN_BIT]}}, half};
endmodule

// ---- rtl/signed_halfword_load_unit.v ----
// data-memory load path for the signed halfword loads
// Overview of operation
// - register-indirect form loads halfword at first source, sign-extends to 32.
// - displacement form address is first source plus signed displacement.
// - indexed form address is first source plus second source.
// - odd address yields any value but never raises an exception.
// - byte order follows the status word byte-order bit.
// - little: base byte is bits 7:0; big: base byte is bits 15:8.
// - true guard writes destination and updates cache status bits.
// - false guard: no write, no cache status update, no side effect.
// - register-indirect is displacement form with zero displacement.
`timescale 1ns/1ps
`include "hword_load_consts.vh"
module signed_halfword_load_unit #(
  parameter REG_IDX_WIDTH = 7
) (
  input wire clk,
  input wire rst_n,
  input wire issueValid,
  input wire [`OPC_WIDTH-1:0] opcode,
  input wire [31:0] firstSourceRegister,
  input wire [31:0] secondSourceRegister,
  input wire [`DISP_WIDTH-1:0] dispModifier,
  input wire guardPresent,
  input wire [31:0] guardValue,
  input wire [REG_IDX_WIDTH-1:0] destIndex,
  input wire byteOrderLittle,
  input wire [7:0] memByteAtBase,
  input wire [7:0] memByteAtNext,
  output reg cacheRead_reg,
  output reg [31:0] cacheAddr_reg,
  output reg writeEnable_reg,
  output reg [REG_IDX_WIDTH-1:0] writeIndex_reg,
  output reg [31:0] writeData_reg
);
  // ***************************************************
  // address generation
  // ***************************************************
  wire [31:0] dispExt;
  wire isIndexed;
  wire guardTrue;
  wire opKnown;
  wire [31:0] addrNext;
  // modifier holds half the even displacement, so scale by two
  assign dispExt = {{(31-`DISP_WIDTH){dispModifier[`DISP_SIGN_BIT]}},
                    dispModifier, 1'b0};
  assign isIndexed = (opcode == `OPC_HWORD_INDEXED);
  assign opKnown = isIndexed || (opcode == `OPC_HWORD_DISP);
  assign guardTrue = !guardPresent || guardValue[0];
  // indirect form arrives with a zero modifier on the same code
  assign addrNext = isIndexed ?
    firstSourceRegister + secondSourceRegister :
    firstSourceRegister + dispExt;

  // ***************************************************
  // pipeline: issue, cache access, write-back
  // ***************************************************
  reg [`LOAD_LATENCY-1:0] stageValid_reg;
  reg [REG_IDX_WIDTH-1:0] idxStage1_reg;
  reg [REG_IDX_WIDTH-1:0] idxStage2_reg;
  reg orderStage1_reg;
  reg orderStage2_reg;
  wire [31:0] assembled;
  wire accept;
  assign accept = issueValid && opKnown && guardTrue;

  hword_assemble hword_assemble_inst (
    .byteAtBase(memByteAtBase),
    .byteAtNext(memByteAtNext),
    .littleEndian(orderStage2_reg),
    .extended(assembled)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stageValid_reg <= {`LOAD_LATENCY{1'b0}};
      idxStage1_reg <= {REG_IDX_WIDTH{1'b0}};
      idxStage2_reg <= {REG_IDX_WIDTH{1'b0}};
      orderStage1_reg <= `ORDER_LITTLE;
      orderStage2_reg <= `ORDER_LITTLE;
      cacheRead_reg <= 1'b0;
      cacheAddr_reg <= `ZERO_ADDR;
      writeEnable_reg <= 1'b0;
      writeIndex_reg <= {REG_IDX_WIDTH{1'b0}};
      writeData_reg <= `ZERO_WORD;
    end else begin
      // cache status only touched for a true guard
      cacheRead_reg <= accept;
      if (accept) begin
        // no alignment check: odd addresses pass through silently
        cacheAddr_reg <= addrNext;
      end
      stageValid_reg <= {stageValid_reg[`LOAD_LATENCY-2:0], accept};
      idxStage1_reg <= destIndex;
      idxStage2_reg <= idxStage1_reg;
      // order sampled at issue so a later status change cannot tear it
      orderStage1_reg <= byteOrderLittle;
      orderStage2_reg <= orderStage1_reg;
      writeEnable_reg <= stageValid_reg[1];
      writeIndex_reg <= idxStage2_reg;
      if (stageValid_reg[1]) begin
        writeData_reg <= assembled;
      end
    end
  end
endmodule

// ---- testbench/hword_load_props.sv ----
// port assertions for the halfword load unit
`timescale 1ns/1ps
`include "hword_load_consts.vh"
module hword_load_props (input wire clk, rst_n, issueValid, guardPresent,
  byteOrderLittle, cacheRead_reg, writeEnable_reg, input wire [6:0]
  dispModifier, input wire [7:0] opcode, memByteAtBase, memByteAtNext,
  input wire [31:0] firstSourceRegister, secondSourceRegister, guardValue,
  cacheAddr_reg,
  writeData_reg);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ok = issueValid && (!guardPresent || guardValue[0]);
  wire [31:0] w = writeData_reg;
  wire [31:0] da = firstSourceRegister
    + {{24{dispModifier[6]}}, dispModifier, 1'b0};
  wire [15:0] le = {memByteAtNext, memByteAtBase};
  property p_ng; issueValid && !ok |=> !cacheRead_reg; endproperty
  a_ng: assert property (p_ng) else $error("read on false guard");
  property p_we; cacheRead_reg |-> ##2 writeEnable_reg; endproperty
  a_we: assert property (p_we) else $error("write missing");
  property p_ix; ok && opcode == `OPC_HWORD_INDEXED |=> cacheAddr_reg ==
    $past(firstSourceRegister + secondSourceRegister); endproperty
  a_ix: assert property (p_ix) else $error("bad index address");
  property p_da; ok && opcode == `OPC_HWORD_DISP |=> cacheAddr_reg ==
    $past(da); endproperty
  a_da: assert property (p_da) else $error("bad address");
  property p_wd; writeEnable_reg |-> $past(le) == ($past(byteOrderLittle, 3)
    ? w[15:0] : {w[7:0], w[15:8]}); endproperty
  a_wd: assert property (p_wd) else $error("bad byte order");
  property p_sx; writeEnable_reg |-> w[31:16] == {16{w[15]}}; endproperty
  a_sx: assert property (p_sx) else $error("bad sign");
endmodule
bind signed_halfword_load_unit hword_load_props hword_load_props_inst (.*);

// ---- testbench/cache_model.sv ----
// data cache stand-in answering the cycle after a read
`timescale 1ns/1ps
module cache_model (input wire clk, cacheRead_reg, input wire [31:0]
  cacheAddr_reg, output reg [7:0] memByteAtBase = 0, memByteAtNext = 0);
  // idle bytes flip every cycle so stale data never passes for an answer
  always @(posedge clk) {memByteAtBase, memByteAtNext} <= cacheRead_reg ?
    {cacheAddr_reg[7:0] ^ 8'h84, cacheAddr_reg[7:0] + 8'h01 ^ 8'h84}
    : ~{memByteAtBase, memByteAtNext};
endmodule

// ---- testbench/testbench.sv ----
// bench for the halfword load unit
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t %h %h", $time, g, e); end end
module testbench;
  reg clk=0, rst_n=0, issueValid=0, guardPresent=1, byteOrderLittle=1;
  reg [7:0] opcode=0; reg [6:0] dispModifier=0, destIndex=0;
  reg [31:0] firstSourceRegister=0, secondSourceRegister=0, guardValue=0;
  wire [7:0] memByteAtBase, memByteAtNext; wire [6:0] writeIndex_reg;
  wire [31:0] cacheAddr_reg, writeData_reg; wire cacheRead_reg, writeEnable_reg;
  integer err_total=0, checks_done=0, cyc=0;
  signed_halfword_load_unit signed_halfword_load_unit_inst (.*);
  cache_model cache_model_inst (.*);
  always #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 400) begin err_total++; final_report; end
  // write pulse stands one cycle: look at it mid-cycle after the edge
  task ld(input [7:0] op, input [31:0] a, b, input [6:0] d,
    input g, o, p, e); begin
    @(posedge clk);
    {opcode, firstSourceRegister, secondSourceRegister} <= {op, a, b};
    {issueValid, guardValue, dispModifier, destIndex} <= {1'b1, 31'h0, g, d, d};
    {guardPresent, byteOrderLittle} <= {p, o};
    @(posedge clk) issueValid <= 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(writeEnable_reg, e)
  end endtask
  // even displacements, plain memory only
  task t_disp; begin
    ld(8'h06, 32'hd00, 0, 7'h3f, 1, 1, 1, 1);
    `CHK(writeData_reg, 32'hfffffbfa)
    `CHK(cacheAddr_reg, 32'h00000d7e)
    ld(8'h06, 32'h100, 0, 7'h40, 1, 0, 1, 1);
    `CHK(writeData_reg, 32'h00000405)
    `CHK(writeIndex_reg, 7'h40)
    ld(8'h06, 32'h80, 0, 0, 1, 1, 1, 1);
    `CHK(writeData_reg, 32'h00000504)
  end endtask
  task t_idx; begin
    ld(8'hc3, 32'hd04, 32'hfffffffc, 0, 1, 1, 1, 1);
    `CHK(writeData_reg, 32'hffff8584)
    ld(8'h06, 32'h80, 0, 0, 0, 1, 1, 0);
    `CHK(writeData_reg, 32'hffff8584)
    `CHK(cacheAddr_reg, 32'h00000d00)
    ld(8'h06, 32'h80, 0, 0, 0, 1, 0, 1);
    `CHK(writeData_reg, 32'h00000504)
    ld(8'h07, 32'h90, 0, 0, 1, 1, 1, 0);
    `CHK(cacheAddr_reg, 32'h00000080)
    ld(8'h06, 32'hd01, 0, 0, 1, 1, 1, 1);
    `CHK(cacheAddr_reg, 32'h00000d01)
  end endtask
  task final_report; begin
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  end endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_disp;
    t_idx;
    final_report;
  end
endmodule
